// ---- csf_defines.vh ----
// constants for the status flag block: register offset, bit positions, op codes
// assumes an 8-bit core whose sequencer tells this block which operation writes back
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH
// register map (word aligned on the bus)
`define CSF_FLAGS_ADDR   8'h00
`define CSF_ACT_ADDR     8'h04
`define CSF_ADDR_W       8
// flag bit positions
`define CSF_BIT_C        0
`define CSF_BIT_HALF     1
`define CSF_BIT_Z        2
`define CSF_BIT_OVF      3
`define CSF_BIT_PDOWN    4
`define CSF_BIT_TIMEOUT  5
`define CSF_BIT_CHAIN    6
`define CSF_BIT_SIGN     7
// bits software may write (all but timeout and power-down)
`define CSF_SW_MASK      8'hcf
// flag register value after reset
`define CSF_FLAGS_RST    8'h00
// alu operation codes from the sequencer
`define CSF_OP_W         4
`define CSF_OP_NONE      4'h0
`define CSF_OP_ADD       4'h1
`define CSF_OP_ADC       4'h2
`define CSF_OP_SUB       4'h3
`define CSF_OP_SUBB      4'h4
`define CSF_OP_AND       4'h5
`define CSF_OP_OR        4'h6
`define CSF_OP_XOR       4'h7
`define CSF_OP_RLC       4'h8
`define CSF_OP_RRC       4'h9
`define CSF_OP_INC       4'ha
`define CSF_OP_DEC       4'hb
`define CSF_OP_CPL       4'hc
`endif

// ---- csf_alu_flags.v ----
// combinational 8-bit alu that also derives carry, half-carry, zero and overflow
// assumes the sequencer presents operands and the current carry in the same cycle
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_alu_flags (
    input  wire [`CSF_OP_W-1:0] op_i,
    input  wire [7:0]           a_i,
    input  wire [7:0]           b_i,
    input  wire                 c_i,
    output reg  [7:0]           res_o,
    output reg                  c_o,
    output reg                  half_o,
    output reg                  ovf_o,
    output reg                  z_o,
    output reg                  arith_o,
    output reg                  logic_o,
    output reg                  rot_o
);
    reg [8:0] sum;    // full sum with carry out
    reg [4:0] lo;     // low nibble sum for half-carry
    reg [7:0] bb;     // second operand, inverted for subtract
    reg       cin;    // carry into bit 0
    reg       c7;     // carry into msb
    // subtract is a + ~b + cin, so carry out means no borrow
    always @* begin
        sum     = 9'h000;
        lo      = 5'h00;
        bb      = b_i;
        cin     = 1'b0;
        c7      = 1'b0;
        res_o   = a_i;
        c_o     = c_i;
        half_o  = 1'b0;
        ovf_o   = 1'b0;
        arith_o = 1'b0;
        logic_o = 1'b0;
        rot_o   = 1'b0;
        case (op_i)
            `CSF_OP_ADD, `CSF_OP_ADC, `CSF_OP_SUB, `CSF_OP_SUBB,
            `CSF_OP_INC, `CSF_OP_DEC: begin
                arith_o = 1'b1;
                case (op_i)
                    `CSF_OP_SUB: begin
                        bb  = ~b_i;
                        cin = 1'b1;
                    end
                    `CSF_OP_SUBB: begin
                        bb  = ~b_i;
                        cin = c_i;
                    end
                    `CSF_OP_ADC: cin = c_i;
                    `CSF_OP_INC: bb  = 8'h01;
                    `CSF_OP_DEC: bb  = 8'hff;
                    default:     cin = 1'b0;
                endcase
                sum   = {1'b0, a_i} + {1'b0, bb} + {8'h00, cin};
                lo    = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
                c7    = a_i[7] ^ bb[7] ^ sum[7];
                res_o = sum[7:0];
                // [RULE6] carry or no borrow
                c_o   = sum[8];
                // [RULE8] low nibble carry
                half_o = lo[4];
                // [RULE10] carry in versus out
                ovf_o = c7 ^ sum[8];
            end
            `CSF_OP_AND: begin
                logic_o = 1'b1;
                res_o   = a_i & b_i;
            end
            `CSF_OP_OR: begin
                logic_o = 1'b1;
                res_o   = a_i | b_i;
            end
            `CSF_OP_XOR: begin
                logic_o = 1'b1;
                res_o   = a_i ^ b_i;
            end
            `CSF_OP_CPL: begin
                logic_o = 1'b1;
                res_o   = ~a_i;
            end
            // [RULE7] carry rotates through
            `CSF_OP_RLC: begin
                rot_o = 1'b1;
                res_o = {a_i[6:0], c_i};
                c_o   = a_i[7];
            end
            `CSF_OP_RRC: begin
                rot_o = 1'b1;
                res_o = {c_i, a_i[7:1]};
                c_o   = a_i[0];
            end
            default: res_o = a_i;
        endcase
        // [RULE9] zero result
        z_o = (res_o == 8'h00);
    end
endmodule

// ---- csf_wb_slave.v ----
// classic wishbone slave front end: decodes, gives ack one cycle after the request
// assumes a single-cycle master that holds the request until ack
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_wb_slave (
    input  wire                   clk_i,
    input  wire                   rst_i,
    input  wire                   cyc_i,
    input  wire                   stb_i,
    input  wire                   we_i,
    input  wire [3:0]             sel_i,
    input  wire [`CSF_ADDR_W-1:0] adr_i,
    input  wire [31:0]            dat_i,
    input  wire [7:0]             flags_i,
    output reg                    ack_o,
    output reg  [31:0]            dat_o,
    output wire                   flags_we_o,
    output wire [7:0]             wdata_o
);
    wire req;   // request pending and not yet answered
    wire hit;   // address maps to the flag register
    assign req        = cyc_i & stb_i & ~ack_o;
    assign hit        = (adr_i == `CSF_FLAGS_ADDR);
    // write lands at the edge ack is sampled; only byte lane 0 carries flags
    assign flags_we_o = ack_o & cyc_i & stb_i & we_i & hit & sel_i[0];
    assign wdata_o    = dat_i[7:0];
    // ack one cycle after request, dropped the cycle after; unmapped reads return zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            if (req & ~we_i) begin
                dat_o <= hit ? {24'h000000, flags_i} : 32'h00000000;
            end
        end
    end
endmodule

// ---- csf_status_flags.v ----
// status flag register of the 8-bit core, with flag update from the alu
// assumes the sequencer pulses wb_en_i in the write-back cycle of each alu operation,
// and pulses the watchdog-refresh and stop strobes for one cycle each
//
// Notes on behaviour
// [RULE1] one 8-bit flag register, fixed bit order
// [RULE2] software writes spare timeout and power-down
// [RULE3] timeout changes only by listed events
// [RULE4] timeout cleared by refresh/stop, set by watchdog
// [RULE5] power-down cleared by refresh, set by stop
// [RULE6] carry means carry out or no borrow
// [RULE7] rotate through carry uses carry flag
// [RULE8] half-carry from low nibble carry/no borrow
// [RULE9] zero flag set on zero result
// [RULE10] overflow is carry-in xor carry-out of msb
// [RULE11] sign-compare is overflow xor result msb
// [RULE12] plain subtract copies zero into chained-zero
// [RULE13] borrow subtract ands chained-zero with zero
// [RULE14] other operations keep chained-zero
// [RULE15] no automatic save on interrupt or call
// [RULE16] power-up clears timeout, power-down only; reset here clears all eight flags
// [RULE17] flags update in the write-back cycle
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_status_flags (
    input  wire                   clk_i,
    input  wire                   rst_i,
    // wishbone slave
    input  wire                   cyc_i,
    input  wire                   stb_i,
    input  wire                   we_i,
    input  wire [3:0]             sel_i,
    input  wire [`CSF_ADDR_W-1:0] adr_i,
    input  wire [31:0]            dat_i,
    output wire                   ack_o,
    output wire [31:0]            dat_o,
    // sequencer and alu side
    input  wire                   wb_en_i,
    input  wire [`CSF_OP_W-1:0]   op_i,
    input  wire [7:0]             a_i,
    input  wire [7:0]             b_i,
    input  wire                   watchdog_refresh_instr_i,
    input  wire                   stop_instr_i,
    input  wire                   watchdog_timeout_i,
    output reg  [7:0]             result_o,
    output wire [7:0]             processor_flags_o
);
    reg  [7:0] processor_flags;  // the flag register
    reg  [7:0] next_flags;       // value loaded at the next edge
    wire [7:0] alu_res;          // alu result
    wire       alu_c;            // carry out of alu
    wire       alu_half;         // half-carry out of alu
    wire       alu_ovf;          // overflow out of alu
    wire       alu_z;            // zero out of alu
    wire       is_arith;         // add/sub family
    wire       is_logic;         // logical family
    wire       is_rot;           // rotate through carry
    wire       sw_we;            // software write strobe
    wire [7:0] sw_data;          // software write data

    // function decoding the subtract family, used for both chained-zero cases
    function [1:0] csf_sub_kind;
        input [`CSF_OP_W-1:0] op;
        begin
            case (op)
                `CSF_OP_SUB: csf_sub_kind = 2'b01;
                `CSF_OP_SUBB: csf_sub_kind = 2'b10;
                default:     csf_sub_kind = 2'b00;
            endcase
        end
    endfunction

    // [RULE1] flag register view
    assign processor_flags_o = processor_flags;

    // bus front end
    csf_wb_slave u_bus (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cyc_i      (cyc_i),
        .stb_i      (stb_i),
        .we_i       (we_i),
        .sel_i      (sel_i),
        .adr_i      (adr_i),
        .dat_i      (dat_i),
        .flags_i    (processor_flags),
        .ack_o      (ack_o),
        .dat_o      (dat_o),
        .flags_we_o (sw_we),
        .wdata_o    (sw_data)
    );

    // alu with flag derivation
    csf_alu_flags u_alu (
        .op_i    (op_i),
        .a_i     (a_i),
        .b_i     (b_i),
        .c_i     (processor_flags[`CSF_BIT_C]),
        .res_o   (alu_res),
        .c_o     (alu_c),
        .half_o  (alu_half),
        .ovf_o   (alu_ovf),
        .z_o     (alu_z),
        .arith_o (is_arith),
        .logic_o (is_logic),
        .rot_o   (is_rot)
    );

    // next flag value: software write first, then the alu write-back wins the
    // arithmetic bits, since the instruction stream owns them in that cycle
    always @* begin
        next_flags = processor_flags;
        // [RULE2] software write masked
        if (sw_we) begin
            next_flags = (processor_flags & ~`CSF_SW_MASK) | (sw_data & `CSF_SW_MASK);
        end
        // [RULE17] write-back cycle update
        if (wb_en_i) begin
            if (is_arith) begin
                next_flags[`CSF_BIT_C]  = alu_c;
                next_flags[`CSF_BIT_HALF] = alu_half;
                next_flags[`CSF_BIT_OVF]  = alu_ovf;
                // [RULE11] overflow xor msb
                next_flags[`CSF_BIT_SIGN] = alu_ovf ^ alu_res[7];
            end
            // [RULE7] rotate updates carry
            if (is_rot) begin
                next_flags[`CSF_BIT_C] = alu_c;
            end
            // [RULE9] zero on arith/logic
            if (is_arith | is_logic) begin
                next_flags[`CSF_BIT_Z] = alu_z;
            end
            // [RULE12] [RULE13] [RULE14] chained zero by family; other ops leave
            // it alone, so a software write landing in the same cycle still sticks
            case (csf_sub_kind(op_i))
                2'b01:   next_flags[`CSF_BIT_CHAIN] = alu_z;
                2'b10:   next_flags[`CSF_BIT_CHAIN] = processor_flags[`CSF_BIT_CHAIN] & alu_z;
                default: next_flags[`CSF_BIT_CHAIN] = next_flags[`CSF_BIT_CHAIN];
            endcase
        end
        // [RULE3] [RULE4] timeout events
        if (watchdog_refresh_instr_i | stop_instr_i) begin
            next_flags[`CSF_BIT_TIMEOUT] = 1'b0;
        end
        // set beats clear when a time-out lands with a refresh
        if (watchdog_timeout_i) begin
            next_flags[`CSF_BIT_TIMEOUT] = 1'b1;
        end
        // [RULE5] power-down events
        if (watchdog_refresh_instr_i) begin
            next_flags[`CSF_BIT_PDOWN] = 1'b0;
        end
        if (stop_instr_i) begin
            next_flags[`CSF_BIT_PDOWN] = 1'b1;
        end
    end

    // flag register; arithmetic bits reset to zero so simulation stays defined,
    // software must not rely on them before the first update
    // [RULE15] no stacking here, nothing saves this register on calls
    always @(posedge clk_i) begin
        if (rst_i) begin
            // [RULE16] power-up values
            processor_flags <= `CSF_FLAGS_RST;
        end else begin
            processor_flags <= next_flags;
        end
    end

    // result register for the write-back path
    always @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= 8'h00;
        end else if (wb_en_i) begin
            result_o <= alu_res;
        end
    end
endmodule

// ---- csf_status_flags_properties.sv ----
// assertions on the status flag block, seen from its top ports only
// assumes one clock, synchronous reset rst_i, flags load where wb_en_i is high
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_status_flags_properties (
    input logic        clk_i,
    input logic        rst_i,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        we_i,
    input logic [3:0]  sel_i,
    input logic [7:0]  adr_i,
    input logic [31:0] dat_i,
    input logic        ack_o,
    input logic [31:0] dat_o,
    input logic        wb_en_i,
    input logic [3:0]  op_i,
    input logic [7:0]  a_i,
    input logic [7:0]  b_i,
    input logic        watchdog_refresh_instr_i,
    input logic        stop_instr_i,
    input logic        watchdog_timeout_i,
    input logic [7:0]  result_o,
    input logic [7:0]  processor_flags_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // add/sub write-back (inc and dec not included), subtract write-back, software write pending
    wire       ar = wb_en_i && op_i >= `CSF_OP_ADD && op_i <= `CSF_OP_SUBB;
    wire       sb = wb_en_i && (op_i == `CSF_OP_SUB || op_i == `CSF_OP_SUBB);
    wire       sw = cyc_i && stb_i && we_i;
    wire [7:0] pf = processor_flags_o;
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_timeout_set: assert property (watchdog_timeout_i |=> pf[5])
        else $error("timeout flag not set");
    a_stop_pd: assert property (stop_instr_i |=> pf[4])
        else $error("power-down flag not set by stop");
    a_refresh_clr: assert property (watchdog_refresh_instr_i && !stop_instr_i
        && !watchdog_timeout_i |=> pf[5:4] == 2'b00) else $error("refresh did not clear");
    a_sys_hold: assert property (!watchdog_refresh_instr_i && !stop_instr_i
        && !watchdog_timeout_i |=> $stable(pf[5:4])) else $error("system flags moved");
    a_chain_copy: assert property (wb_en_i && op_i == `CSF_OP_SUB
        |=> pf[6] == pf[2]) else $error("chained zero not copied");
    a_chain_and: assert property (wb_en_i && op_i == `CSF_OP_SUBB
        |=> pf[6] == ($past(pf[6]) && pf[2])) else $error("chained zero not anded");
    a_chain_keep: assert property (!sb && !sw |=> $stable(pf[6]))
        else $error("chained zero moved");
    a_sign_xor: assert property (ar |=> pf[7] == (pf[3] ^ result_o[7]))
        else $error("sign compare wrong");
    a_add_sum: assert property (wb_en_i && op_i == `CSF_OP_ADD
        |=> {pf[0], result_o} == $past(a_i) + $past(b_i)) else $error("add carry wrong");
    c_subb: cover property (wb_en_i && op_i == `CSF_OP_SUBB);
    c_stop: cover property (stop_instr_i);
    c_wr: cover property (ack_o && we_i);
    c_tie: cover property (watchdog_timeout_i && watchdog_refresh_instr_i);
    c_inc: cover property (wb_en_i && op_i == `CSF_OP_INC);
endmodule
bind csf_status_flags csf_status_flags_properties csf_status_flags_properties_inst (.*);

// ---- csf_seq_model.sv ----
// sequencer stand-in: write-back strobes and instruction pulses
// assumes callers are in step with the core clock
`timescale 1ns/1ps
module csf_seq_model (
    input  wire       clk_i,
    output reg        wb_en_o,
    output reg  [3:0] op_o,
    output reg  [7:0] a_o,
    output reg  [7:0] b_o,
    output reg        refresh_o,
    output reg        stop_o,
    output reg        timeout_o
);
    // idle at time zero
    initial begin
        {wb_en_o, op_o, a_o, b_o, refresh_o, stop_o, timeout_o} = 24'h0;
    end
    // one write-back cycle; operands scrambled after it so stale values never pass
    task issue(input [3:0] op, input [7:0] a, input [7:0] b);
        @(posedge clk_i);
        {wb_en_o, op_o, a_o, b_o} <= {1'b1, op, a, b};
        @(posedge clk_i);
        {wb_en_o, a_o, b_o} <= {1'b0, ~a, ~b};
    endtask
    // one-cycle pulse of {timeout, stop, refresh}
    task pulse(input [2:0] k);
        @(posedge clk_i);
        {timeout_o, stop_o, refresh_o} <= k;
        @(posedge clk_i);
        {timeout_o, stop_o, refresh_o} <= 3'h0;
    endtask
endmodule

// ---- csf_status_flags_tb.sv ----
// self-checking bench for the status flag block
// assumes the sequencer model beside it and the bound checker
`timescale 1ns/1ps
`include "csf_defines.vh"
module csf_status_flags_tb;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg  [3:0]  sel = 4'h1;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] dat = 32'h0, q, seed = 32'h6;
    reg  [7:0]  ef = 8'h00;  // expected flags
    reg  [15:0] e;
    integer     fails = 0, n_checks = 0, i;
    wire        ack, wbe, rf, sp, wd;
    wire [3:0]  op;
    wire [7:0]  a, b, res, pf;
    wire [31:0] rd;
    always #5 clk_i = ~clk_i;
    csf_seq_model csf_seq_model_inst (.clk_i(clk_i), .wb_en_o(wbe), .op_o(op), .a_o(a),
        .b_o(b), .refresh_o(rf), .stop_o(sp), .timeout_o(wd));
    csf_status_flags csf_status_flags_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(dat), .ack_o(ack),
        .dat_o(rd), .wb_en_i(wbe), .op_i(op), .a_i(a), .b_i(b), .watchdog_refresh_instr_i(rf),
        .stop_instr_i(sp), .watchdog_timeout_i(wd), .result_o(res), .processor_flags_o(pf));
    function [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction
    // expected {result, flags}; subtract adds the inverted operand, inc/dec add 1 or ff
    function [15:0] nf(input [3:0] o, input [7:0] x, input [7:0] y, input [7:0] f);
        reg [8:0] s;
        reg [4:0] h;
        reg [7:0] yy, r, g;
        reg       ci, ar;
        begin
            g  = f;
            ar = (o >= `CSF_OP_ADD && o <= `CSF_OP_SUBB) ||
                 o == `CSF_OP_INC || o == `CSF_OP_DEC;
            yy = (o == `CSF_OP_INC) ? 8'h01 : (o == `CSF_OP_DEC) ? 8'hff :
                 (o == `CSF_OP_SUB || o == `CSF_OP_SUBB) ? ~y : y;
            ci = (o == `CSF_OP_SUB) ? 1'b1 :
                 (o == `CSF_OP_ADC || o == `CSF_OP_SUBB) ? f[0] : 1'b0;
            s  = x + yy + ci;
            h  = x[3:0] + yy[3:0] + ci;
            case (o)
                `CSF_OP_AND: r = x & y;
                `CSF_OP_OR:  r = x | y;
                `CSF_OP_XOR: r = x ^ y;
                `CSF_OP_RLC: r = {x[6:0], f[0]};
                `CSF_OP_RRC: r = {f[0], x[7:1]};
                `CSF_OP_CPL: r = ~x;
                default:     r = ar ? s[7:0] : x;
            endcase
            if (ar) begin
                g[0] = s[8];
                g[1] = h[4];
                g[3] = s[8] ^ s[7] ^ x[7] ^ yy[7];
                g[7] = g[3] ^ r[7];
            end
            if (o == `CSF_OP_RLC || o == `CSF_OP_RRC) g[0] = o[0] ? x[0] : x[7];
            else if (o != `CSF_OP_NONE) g[2] = (r == 8'h00);
            if (o == `CSF_OP_SUB) g[6] = g[2];
            if (o == `CSF_OP_SUBB) g[6] = f[6] & g[2];
            nf = {r, g};
        end
    endfunction
    task chk(input [31:0] g, input [31:0] x);
        n_checks = n_checks + 1;
        if (g !== x) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task wb(input w, input [7:0] ad, input [31:0] d, input [3:0] s);
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            {cyc, stb, we, adr, dat, sel} <= {2'b11, w, ad, d, s};
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack !== 1'b1 && n < 20);
            // a slave that never answers ends the run as a failure
            if (n >= 20) begin
                fails = fails + 1;
                end_sim;
            end
            q = rd;
            {cyc, stb} <= 2'b00;
        end
    endtask
    task alu(input [3:0] o, input [7:0] x, input [7:0] y);
        csf_seq_model_inst.issue(o, x, y);
        e = nf(o, x, y, ef);
        ef = e[7:0];
        @(negedge clk_i);
        chk(res, e[15:8]);
        chk(pf, ef);
    endtask
    // bits: {timeout, stop, refresh}; set and stop win their ties
    task ev(input [2:0] k);
        csf_seq_model_inst.pulse(k);
        if (k[0]) ef[5:4] = 2'b00;
        if (k[1]) ef[5:4] = 2'b01;
        if (k[2]) ef[5] = 1'b1;
        @(negedge clk_i);
        chk(pf, ef);
    endtask
    task end_sim;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(pf, 32'h00);
        wb(1'b1, `CSF_FLAGS_ADDR, 32'hff, 4'h1);
        wb(1'b1, 8'h10, 32'h00, 4'h1);
        wb(1'b1, `CSF_FLAGS_ADDR, 32'h00, 4'h0);
        wb(1'b0, 8'h10, 32'h0, 4'h1);
        chk(q, 32'h0);
        wb(1'b0, `CSF_FLAGS_ADDR, 32'h0, 4'h1);
        chk(q, 32'hcf);
        $display("test bus done");
        ef = 8'hcf;
        ev(3'h4);
        wb(1'b1, `CSF_FLAGS_ADDR, 32'h00, 4'h1);
        wb(1'b0, `CSF_FLAGS_ADDR, 32'h0, 4'h1);
        chk(q, 32'h20);
        ef = 8'h20;
        ev(3'h2);
        ev(3'h6);
        ev(3'h1);
        ev(3'h3);
        ev(3'h5);
        // reset in mid-run while the timeout flag is set: it must come back clear
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(pf, 32'h00);
        ef = 8'h00;
        $display("test events done");
        alu(`CSF_OP_ADD, 8'h80, 8'h80);
        alu(`CSF_OP_ADD, 8'h0f, 8'h01);
        alu(`CSF_OP_SUB, 8'h05, 8'h05);
        alu(`CSF_OP_SUBB, 8'h00, 8'h00);
        alu(`CSF_OP_RLC, 8'h81, 8'h00);
        alu(`CSF_OP_RRC, 8'h01, 8'h00);
        alu(`CSF_OP_INC, 8'hff, 8'h00);
        alu(`CSF_OP_DEC, 8'h00, 8'h00);
        alu(`CSF_OP_CPL, 8'hff, 8'h00);
        alu(`CSF_OP_NONE, 8'h5a, 8'h00);
        for (i = 0; i < 200; i = i + 1) begin
            q = xs();
            alu(q[3:0] % 4'd13, q[15:8], q[23:16]);
        end
        $display("test alu done");
        end_sim;
    end
    initial begin
        #100000;
        fails = fails + 1;
        end_sim;
    end
endmodule
